//--- src/dual_port_gpio_analog_mux.sv
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dual_port_gpio_analog_mux
  import gpio_pkg::*;
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  // avalon-mm slave
  input  wire avm_req_type         avm_req,
  output avm_rsp_type              avm_rsp,
  // port a pads
  input  wire logic [PA_WIDTH-1:0] pa_in,
  output logic      [PA_WIDTH-1:0] pa_out,
  output logic      [PA_WIDTH-1:0] pa_oe_n,
  output logic      [PA_WIDTH-1:0] pa_schmitt_sel,
  // port f pads, bit 0 is pin 1
  input  wire logic [PF_WIDTH-1:0] pf_in,
  output logic      [PF_WIDTH-1:0] pf_out,
  output logic      [PF_WIDTH-1:0] pf_oe_n,
  output logic      [PF_WIDTH-1:0] pf_schmitt_sel,
  // shared functions
  input  wire logic                osc_frees_pa76,
  input  wire logic [1:0]          lcd_seg_drive,
  output logic                     timer_zero_ext_clock,
  output logic      [7:0]          analog_enable_low,
  output logic      [7:0]          analog_enable_high,
  output logic      [5:0]          comparator_pin_enable
);

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0]          port_a_output_latch_reg;
  logic [7:0]          port_a_direction_reg;
  logic [7:0]          analog_select_low_reg;
  logic [7:0]          analog_select_high_reg;
  logic [7:0]          comparator_control_reg;
  logic [7:0]          port_f_output_latch_reg;
  logic [7:0]          port_f_direction_reg;
  logic [7:0]          segment_enable_mid_reg;
  logic [7:0]          segment_enable_high_reg;
  logic                waitrequest_reg;
  logic [31:0]         readdata_reg;
  logic [31:0]         readdata_next;
  logic [PA_WIDTH-1:0] pa_sync;
  logic [PF_WIDTH-1:0] pf_sync;
  logic [7:0]          pa_analog_mask;
  logic [7:0]          pa_live_mask;
  logic [7:0]          pa_read_value;
  logic [7:0]          pf_analog_mask;
  logic [7:0]          pf_read_value;
  logic [7:0]          pa_seg_mask;
  logic [7:0]          pa_drive_value;
  logic [7:0]          pa_oe_n_next;
  logic                accept_write;
  logic                byte0_write;

  ////////////////////////////////////////////////////////////////////////
  // pad inputs cross into clk_sys before anything looks at them
  pin_sync #(.WIDTH(PA_WIDTH)) u_pa_sync (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .pin_async    (pa_in),
    .pin_sync_out (pa_sync)
  );

  pin_sync #(.WIDTH(PF_WIDTH)) u_pf_sync (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .pin_async    (pf_in),
    .pin_sync_out (pf_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // pin function masks
  always_comb begin
    // port a analog pins: 3:0 from bits 3:0, pin 5 from bit 4
    pa_analog_mask                 = {4'h0, analog_select_low_reg[3:0]};
    pa_analog_mask[PA_ANALOG_PIN5] = analog_select_low_reg[SEL_BIT_PA5];
    // pa7/pa6 vanish unless the oscillator leaves them free
    pa_live_mask = osc_frees_pa76 ? 8'hFF : ~PA_OSC_PINS;
    // port f pins 7:1 analog from upper selects or comparator use
    pf_analog_mask = {analog_select_high_reg[3:0], analog_select_low_reg[7:5], 1'b0};
    pf_analog_mask[COMP_HIGH_BIT:COMP_LOW_BIT] =
      pf_analog_mask[COMP_HIGH_BIT:COMP_LOW_BIT]
      | comparator_control_reg[COMP_HIGH_BIT:COMP_LOW_BIT];
    // analog pins read zero, missing pins read zero
    pa_read_value = pa_sync & ~pa_analog_mask & pa_live_mask;
    pf_read_value = {pf_sync, 1'b0} & ~pf_analog_mask;
  end

  ////////////////////////////////////////////////////////////////////////
  // segment override and drive enables on port a
  always_comb begin
    pa_seg_mask                 = 8'h00;
    pa_seg_mask[PA_SEG_PIN4]    = segment_enable_mid_reg[SEG_BIT_PA4];
    pa_seg_mask[PA_SEG_PIN1]    = segment_enable_mid_reg[SEG_BIT_PA1];
    pa_drive_value              = port_a_output_latch_reg;
    pa_drive_value[PA_SEG_PIN4] = pa_seg_mask[PA_SEG_PIN4] ? lcd_seg_drive[0]
                                                           : port_a_output_latch_reg[PA_SEG_PIN4];
    pa_drive_value[PA_SEG_PIN1] = pa_seg_mask[PA_SEG_PIN1] ? lcd_seg_drive[1]
                                                           : port_a_output_latch_reg[PA_SEG_PIN1];
    // direction still rules analog pins; software must keep them input
    pa_oe_n_next = (port_a_direction_reg & ~pa_seg_mask) | ~pa_live_mask;
  end

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then answer for exactly one cycle
  assign accept_write = avm_req.write && !waitrequest_reg;
  assign byte0_write  = accept_write && avm_req.byteenable[0];

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      waitrequest_reg <= 1'b1;
    end else if ((avm_req.read || avm_req.write) && waitrequest_reg) begin
      waitrequest_reg <= 1'b0;
    end else begin
      waitrequest_reg <= 1'b1;
    end
  end

  // read mux; upper 24 bits and unmapped words read zero
  always_comb begin
    readdata_next = 32'h0000_0000;
    case (avm_req.address)
      IDX_PORT_A_PINS:         readdata_next[7:0] = pa_read_value;
      IDX_PORT_A_OUTPUT_LATCH: readdata_next[7:0] = port_a_output_latch_reg;
      IDX_PORT_A_DIRECTION:    readdata_next[7:0] = port_a_direction_reg & pa_live_mask;
      IDX_ANALOG_SELECT_LOW:   readdata_next[7:0] = analog_select_low_reg;
      IDX_ANALOG_SELECT_HIGH:  readdata_next[7:0] = analog_select_high_reg;
      IDX_COMPARATOR_CONTROL:  readdata_next[7:0] = comparator_control_reg;
      IDX_PORT_F_PINS:         readdata_next[7:0] = pf_read_value;
      IDX_PORT_F_OUTPUT_LATCH: readdata_next[7:0] = port_f_output_latch_reg;
      IDX_PORT_F_DIRECTION:    readdata_next[7:0] = port_f_direction_reg;
      IDX_SEGMENT_ENABLE_MID:  readdata_next[7:0] = segment_enable_mid_reg;
      IDX_SEGMENT_ENABLE_HIGH: readdata_next[7:0] = segment_enable_high_reg;
      default:                 readdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      readdata_reg <= 32'h0000_0000;
    end else if (avm_req.read && waitrequest_reg) begin
      readdata_reg <= readdata_next;
    end
  end

  assign avm_rsp.readdata    = readdata_reg;
  assign avm_rsp.waitrequest = waitrequest_reg;

  ////////////////////////////////////////////////////////////////////////
  // port a registers; pin writes land in the latch
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      port_a_output_latch_reg <= RST_LATCH;
      port_a_direction_reg    <= RST_DIRECTION;
    end else if (byte0_write) begin
      if (avm_req.address == IDX_PORT_A_PINS || avm_req.address == IDX_PORT_A_OUTPUT_LATCH) begin
        port_a_output_latch_reg <= avm_req.writedata[7:0];
      end
      if (avm_req.address == IDX_PORT_A_DIRECTION) begin
        port_a_direction_reg <= avm_req.writedata[7:0];
      end
    end
  end

  // analog, comparator and segment configuration
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      analog_select_low_reg   <= RST_ANALOG;
      analog_select_high_reg  <= RST_ANALOG;
      comparator_control_reg  <= RST_COMPARE;
      segment_enable_mid_reg  <= RST_SEGMENT;
      segment_enable_high_reg <= RST_SEGMENT;
    end else if (byte0_write) begin
      case (avm_req.address)
        IDX_ANALOG_SELECT_LOW:   analog_select_low_reg   <= avm_req.writedata[7:0];
        IDX_ANALOG_SELECT_HIGH:  analog_select_high_reg  <= avm_req.writedata[7:0];
        IDX_COMPARATOR_CONTROL:  comparator_control_reg  <= avm_req.writedata[7:0];
        IDX_SEGMENT_ENABLE_MID:  segment_enable_mid_reg  <= avm_req.writedata[7:0];
        IDX_SEGMENT_ENABLE_HIGH: segment_enable_high_reg <= avm_req.writedata[7:0];
        default: begin
        end
      endcase
    end
  end

  // port f registers; bit 0 has no pin and stays zero
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      port_f_output_latch_reg <= RST_LATCH;
      port_f_direction_reg    <= {RST_DIRECTION[7:1], 1'b0};
    end else if (byte0_write) begin
      if (avm_req.address == IDX_PORT_F_PINS || avm_req.address == IDX_PORT_F_OUTPUT_LATCH) begin
        port_f_output_latch_reg <= {avm_req.writedata[7:1], 1'b0};
      end
      if (avm_req.address == IDX_PORT_F_DIRECTION) begin
        port_f_direction_reg <= {avm_req.writedata[7:1], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pad and peripheral outputs
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pa_out         <= 8'h00;
      pa_oe_n        <= 8'hFF;
      pa_schmitt_sel <= PA_SCHMITT_MASK;
      pf_out         <= 7'h00;
      pf_oe_n        <= 7'h7F;
      pf_schmitt_sel <= PF_SCHMITT_MASK;
    end else begin
      pa_out         <= pa_drive_value & pa_live_mask;
      pa_oe_n        <= pa_oe_n_next;
      pa_schmitt_sel <= PA_SCHMITT_MASK;
      pf_out         <= port_f_output_latch_reg[7:1];
      pf_oe_n        <= port_f_direction_reg[7:1];
      pf_schmitt_sel <= PF_SCHMITT_MASK;
    end
  end

  // the timer clock taps pa4 whatever else the pin does
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      timer_zero_ext_clock  <= 1'b0;
      analog_enable_low     <= 8'h00;
      analog_enable_high    <= 8'h00;
      comparator_pin_enable <= 6'h00;
    end else begin
      timer_zero_ext_clock  <= pa_sync[PA_TIMER_CLK_BIT];
      analog_enable_low     <= analog_select_low_reg;
      analog_enable_high    <= analog_select_high_reg;
      comparator_pin_enable <= comparator_control_reg[COMP_HIGH_BIT:COMP_LOW_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_dir_to_oe;
    @(posedge clk_sys) disable iff (!resetn)
      (osc_frees_pa76 && segment_enable_mid_reg == 8'h00)
      |=> pa_oe_n == $past(port_a_direction_reg);
  endproperty
  a_dir_to_oe: assert property (p_dir_to_oe)
    else $error("port a enable does not follow direction");

  property p_analog_reads_zero;
    @(posedge clk_sys) disable iff (!resetn)
      (avm_req.read && waitrequest_reg && avm_req.address == IDX_PORT_A_PINS)
      |=> (avm_rsp.readdata[3:0] & $past(analog_select_low_reg[3:0])) == 4'h0;
  endproperty
  a_analog_reads_zero: assert property (p_analog_reads_zero)
    else $error("analog port a pin read non-zero");

  property p_pf_reset_analog;
    @(posedge clk_sys) $rose(resetn) |-> pf_analog_mask[7:1] == 7'h7F;
  endproperty
  a_pf_reset_analog: assert property (p_pf_reset_analog)
    else $error("port f not analog after reset");

  property p_osc_pins_off;
    @(posedge clk_sys) disable iff (!resetn)
      !osc_frees_pa76 [*2] |-> pa_oe_n[7:6] == 2'b11;
  endproperty
  a_osc_pins_off: assert property (p_osc_pins_off)
    else $error("pa7/pa6 driven while taken by oscillator");

  property p_latch_write;
    @(posedge clk_sys) disable iff (!resetn)
      (byte0_write && avm_req.address == IDX_PORT_A_PINS)
      |=> port_a_output_latch_reg == $past(avm_req.writedata[7:0]);
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("pin register write missed the latch");

  property p_upper_zero;
    @(posedge clk_sys) disable iff (!resetn)
      !waitrequest_reg |-> avm_rsp.readdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("unimplemented read bits not zero");

  property p_timer_tap;
    @(posedge clk_sys) disable iff (!resetn)
      $rose(pa_sync[PA_TIMER_CLK_BIT]) |=> timer_zero_ext_clock;
  endproperty
  a_timer_tap: assert property (p_timer_tap)
    else $error("timer clock does not follow pa4");

  property p_pf_dir;
    @(posedge clk_sys) disable iff (!resetn)
      (byte0_write && avm_req.address == IDX_PORT_F_DIRECTION)
      |=> ##1 pf_oe_n == $past(avm_req.writedata[7:1], 2);
  endproperty
  a_pf_dir: assert property (p_pf_dir)
    else $error("port f enable does not follow direction write");

  property p_comp_reads_zero;
    @(posedge clk_sys) disable iff (!resetn)
      comparator_control_reg[COMP_LOW_BIT] |-> pf_read_value[1] == 1'b0;
  endproperty
  a_comp_reads_zero: assert property (p_comp_reads_zero)
    else $error("comparator pin read non-zero");

  property p_answer_one_cycle;
    @(posedge clk_sys) disable iff (!resetn)
      ((avm_req.read || avm_req.write) && waitrequest_reg) |=> !waitrequest_reg ##1 waitrequest_reg;
  endproperty
  a_answer_one_cycle: assert property (p_answer_one_cycle)
    else $error("bus answer not one cycle after request");

endmodule
`default_nettype wire

//--- src/gpio_pkg.sv
package gpio_pkg;

  // port geometry
  localparam int PA_WIDTH = 8;
  localparam int PF_WIDTH = 7;
  localparam int PF_LOW_BIT = 1;

  // register word indexes on the bus
  localparam logic [3:0] IDX_PORT_A_PINS           = 4'h0;
  localparam logic [3:0] IDX_PORT_A_OUTPUT_LATCH   = 4'h1;
  localparam logic [3:0] IDX_PORT_A_DIRECTION      = 4'h2;
  localparam logic [3:0] IDX_ANALOG_SELECT_LOW     = 4'h3;
  localparam logic [3:0] IDX_ANALOG_SELECT_HIGH    = 4'h4;
  localparam logic [3:0] IDX_COMPARATOR_CONTROL    = 4'h5;
  localparam logic [3:0] IDX_PORT_F_PINS           = 4'h6;
  localparam logic [3:0] IDX_PORT_F_OUTPUT_LATCH   = 4'h7;
  localparam logic [3:0] IDX_PORT_F_DIRECTION      = 4'h8;
  localparam logic [3:0] IDX_SEGMENT_ENABLE_MID    = 4'h9;
  localparam logic [3:0] IDX_SEGMENT_ENABLE_HIGH   = 4'hA;

  // values after reset
  localparam logic [7:0] RST_LATCH     = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_ANALOG    = 8'hFF;
  localparam logic [7:0] RST_COMPARE   = 8'h00;
  localparam logic [7:0] RST_SEGMENT   = 8'h00;

  // field positions
  localparam int PA_TIMER_CLK_BIT = 4;
  localparam int PA_ANALOG_PIN5   = 5;
  localparam int SEL_BIT_PA5      = 4;
  localparam int PA_SEG_PIN4      = 4;
  localparam int PA_SEG_PIN1      = 1;
  localparam int SEG_BIT_PA4      = 0;
  localparam int SEG_BIT_PA1      = 1;
  localparam int COMP_LOW_BIT     = 1;
  localparam int COMP_HIGH_BIT    = 6;

  // input buffer kind per pin: 1 = schmitt, 0 = ttl
  localparam logic [7:0] PA_SCHMITT_MASK = 8'h10;
  localparam logic [6:0] PF_SCHMITT_MASK = 7'h7F;
  // pins 7 and 6 of port a depend on the oscillator mode
  localparam logic [7:0] PA_OSC_PINS     = 8'hC0;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avm_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avm_rsp_type;

endpackage

//--- src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // asynchronous pins and their synchronised copy
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_sync_out
);

  // a width below one leaves nothing to synchronise
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync width must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////
  // two stages per pin; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg;
      logic stable_reg;
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          meta_reg   <= 1'b0;
          stable_reg <= 1'b0;
        end else begin
          meta_reg   <= pin_async[i];
          stable_reg <= meta_reg;
        end
      end
      assign pin_sync_out[i] = stable_reg;
    end
  endgenerate

endmodule
`default_nettype wire

//--- sim/gpio_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_board_model
  import gpio_pkg::*;
(
  // pad drive from the block
  input  wire logic [PA_WIDTH-1:0] pa_out,
  input  wire logic [PA_WIDTH-1:0] pa_oe_n,
  input  wire logic [PF_WIDTH-1:0] pf_out,
  input  wire logic [PF_WIDTH-1:0] pf_oe_n,
  // levels the board circuits put on undriven pads
  input  wire logic [PA_WIDTH-1:0] pa_drive,
  input  wire logic [PF_WIDTH-1:0] pf_drive,
  // resolved pad levels seen by the block
  output logic      [PA_WIDTH-1:0] pa_in,
  output logic      [PF_WIDTH-1:0] pf_in
);
  ////////////////////////////////////////////////////////////////////////////
  // wire level: a pad the block drives shows its value, else the board level
  // board sources are weak, so the block's driver always wins a contention
  always_comb begin
    for (int i = 0; i < PA_WIDTH; i++) begin
      pa_in[i] = (pa_oe_n[i] === 1'b0) ? pa_out[i] : pa_drive[i];
    end
    for (int i = 0; i < PF_WIDTH; i++) begin
      pf_in[i] = (pf_oe_n[i] === 1'b0) ? pf_out[i] : pf_drive[i];
    end
  end
endmodule
`default_nettype wire

//--- sim/dual_port_gpio_analog_mux_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dual_port_gpio_analog_mux_tb
  import gpio_pkg::*;
;
  logic                clk_sys = 1'b0;
  logic                resetn = 1'b0;
  avm_req_type         avm_req = '0;
  avm_rsp_type         avm_rsp;
  logic [PA_WIDTH-1:0] pa_in, pa_out, pa_oe_n, pa_schmitt_sel, pa_drive = 8'hFF;
  logic [PF_WIDTH-1:0] pf_in, pf_out, pf_oe_n, pf_schmitt_sel, pf_drive = 7'h7F;
  logic                osc_frees_pa76 = 1'b1;
  logic [1:0]          lcd_seg_drive = 2'b00;
  logic                timer_zero_ext_clock;
  logic [7:0]          analog_enable_low, analog_enable_high;
  logic [5:0]          comparator_pin_enable;
  int                  n_fail = 0;
  int                  compares = 0;
  int                  cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock, 25 ns period
  always #12.5 clk_sys = ~clk_sys;

  dual_port_gpio_analog_mux dual_port_gpio_analog_mux_inst (
    .clk_sys(clk_sys), .resetn(resetn), .avm_req(avm_req), .avm_rsp(avm_rsp),
    .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pa_schmitt_sel(pa_schmitt_sel),
    .pf_in(pf_in), .pf_out(pf_out), .pf_oe_n(pf_oe_n), .pf_schmitt_sel(pf_schmitt_sel),
    .osc_frees_pa76(osc_frees_pa76), .lcd_seg_drive(lcd_seg_drive),
    .timer_zero_ext_clock(timer_zero_ext_clock), .analog_enable_low(analog_enable_low),
    .analog_enable_high(analog_enable_high), .comparator_pin_enable(comparator_pin_enable)
  );

  gpio_board_model gpio_board_model_inst (
    .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pf_out(pf_out), .pf_oe_n(pf_oe_n),
    .pa_drive(pa_drive), .pf_drive(pf_drive), .pa_in(pa_in), .pf_in(pf_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // verdict and hang guard; the whole run needs well under 1000 cycles
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one avalon access; the idle edge first keeps two drives out of one step
  task automatic bus_access(input logic wr, input logic [3:0] idx, input logic [7:0] wdata,
                            input logic be, output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge clk_sys);
    avm_req.read <= ~wr;
    avm_req.write <= wr;
    avm_req.address <= idx;
    avm_req.writedata <= {24'h000000, wdata};
    avm_req.byteenable <= {3'b000, be};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avm_rsp.waitrequest !== 1'b0);
    rdata = avm_rsp.readdata;
    // one wait edge, then the answer edge; a hang is left to the bench timeout
    check("wait_edges", n, 2);
    avm_req.read <= 1'b0;
    avm_req.write <= 1'b0;
  endtask

  task automatic wr_reg(input logic [3:0] idx, input logic [7:0] wdata);
    logic [31:0] dummy;
    bus_access(1'b1, idx, wdata, 1'b1, dummy);
  endtask

  // upper bits of every read must be zero as well
  task automatic rd_chk(input string what, input logic [3:0] idx, input logic [7:0] exp);
    logic [31:0] rdata;
    bus_access(1'b0, idx, 8'h00, 1'b1, rdata);
    check(what, rdata, {24'h000000, exp});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] junk;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    settle(4);
    // reset state, all analog selects set
    rd_chk("latch_a", IDX_PORT_A_OUTPUT_LATCH, RST_LATCH);
    rd_chk("dir_a", IDX_PORT_A_DIRECTION, RST_DIRECTION);
    rd_chk("asel_low", IDX_ANALOG_SELECT_LOW, RST_ANALOG);
    rd_chk("asel_high", IDX_ANALOG_SELECT_HIGH, RST_ANALOG);
    rd_chk("pins_f", IDX_PORT_F_PINS, 8'h00);
    rd_chk("pins_a", IDX_PORT_A_PINS, 8'hD0);
    rd_chk("dir_f", IDX_PORT_F_DIRECTION, 8'hFE);
    rd_chk("unmapped", 4'hB, 8'h00);
    check("pa_oe_n", pa_oe_n, 8'hFF);
    check("pa_schmitt", pa_schmitt_sel, 8'h10);
    check("pf_schmitt", pf_schmitt_sel, 7'h7F);
    check("an_en_low", analog_enable_low, 8'hFF);
    check("an_en_high", analog_enable_high, 8'hFF);
    $display("test reset done");
    // port a digital output and input
    wr_reg(IDX_ANALOG_SELECT_LOW, 8'h00);
    wr_reg(IDX_PORT_A_PINS, 8'hA5);
    rd_chk("latch_a", IDX_PORT_A_OUTPUT_LATCH, 8'hA5);
    wr_reg(IDX_PORT_A_DIRECTION, 8'h00);
    settle(2);
    check("pa_oe_n", pa_oe_n, 8'h00);
    check("pa_out", pa_out, 8'hA5);
    settle(4);
    rd_chk("pins_a", IDX_PORT_A_PINS, 8'hA5);
    pa_drive <= 8'hDA;
    wr_reg(IDX_PORT_A_DIRECTION, 8'hBF);
    settle(2);
    check("pa_oe_n", pa_oe_n, 8'hBF);
    settle(4);
    rd_chk("pins_a", IDX_PORT_A_PINS, 8'h9A);
    bus_access(1'b1, IDX_PORT_A_OUTPUT_LATCH, 8'h00, 1'b0, junk);
    rd_chk("latch_be0", IDX_PORT_A_OUTPUT_LATCH, 8'hA5);
    $display("test port a done");
    // analog pins read zero while direction keeps the drivers
    wr_reg(IDX_ANALOG_SELECT_LOW, 8'h0F);
    settle(2);
    check("an_en_low", analog_enable_low, 8'h0F);
    check("pa_oe_n", pa_oe_n, 8'hBF);
    rd_chk("pins_a", IDX_PORT_A_PINS, 8'h90);
    // oscillator takes pins 7 and 6
    osc_frees_pa76 <= 1'b0;
    settle(2);
    check("pa_oe_n76", pa_oe_n[7:6], 2'b11);
    check("pa_out76", pa_out[7:6], 2'b00);
    rd_chk("dir_a", IDX_PORT_A_DIRECTION, 8'h3F);
    rd_chk("pins_a", IDX_PORT_A_PINS, 8'h10);
    osc_frees_pa76 <= 1'b1;
    $display("test analog and oscillator done");
    // segment drive on pins 4 and 1, then timer clock from pin 4
    lcd_seg_drive <= 2'b10;
    wr_reg(IDX_SEGMENT_ENABLE_MID, 8'h03);
    settle(2);
    check("seg_oe", {pa_oe_n[4], pa_oe_n[1]}, 2'b00);
    check("seg_out", {pa_out[4], pa_out[1]}, 2'b01);
    rd_chk("seg_mid", IDX_SEGMENT_ENABLE_MID, 8'h03);
    wr_reg(IDX_SEGMENT_ENABLE_HIGH, 8'h5A);
    rd_chk("seg_high", IDX_SEGMENT_ENABLE_HIGH, 8'h5A);
    wr_reg(IDX_SEGMENT_ENABLE_MID, 8'h00);
    settle(4);
    check("timer_hi", timer_zero_ext_clock, 1'b1);
    @(posedge clk_sys);
    pa_drive <= 8'hCA;
    settle(2);
    check("timer_hold", timer_zero_ext_clock, 1'b1);
    settle(1);
    check("timer_lo", timer_zero_ext_clock, 1'b0);
    $display("test segment and timer done");
    // port f to digital, then comparator pins
    wr_reg(IDX_ANALOG_SELECT_HIGH, 8'h00);
    wr_reg(IDX_ANALOG_SELECT_LOW, 8'h00);
    wr_reg(IDX_COMPARATOR_CONTROL, 8'h00);
    wr_reg(IDX_PORT_F_PINS, 8'h33);
    rd_chk("latch_f0", IDX_PORT_F_OUTPUT_LATCH, 8'h32);
    wr_reg(IDX_PORT_F_OUTPUT_LATCH, 8'hAA);
    rd_chk("latch_f", IDX_PORT_F_OUTPUT_LATCH, 8'hAA);
    pf_drive <= 7'h00;
    wr_reg(IDX_PORT_F_DIRECTION, 8'hCE);
    settle(2);
    check("pf_oe_n", pf_oe_n, 7'h67);
    check("pf_out", pf_out, 7'h55);
    check("an_en_high", analog_enable_high, 8'h00);
    settle(4);
    rd_chk("pins_f", IDX_PORT_F_PINS, 8'h20);
    pf_drive <= 7'h7F;
    wr_reg(IDX_COMPARATOR_CONTROL, 8'h7E);
    settle(2);
    check("comp_en", comparator_pin_enable, 6'h3F);
    settle(4);
    rd_chk("pins_f_cmp", IDX_PORT_F_PINS, 8'h80);
    wr_reg(IDX_COMPARATOR_CONTROL, 8'h00);
    rd_chk("pins_f", IDX_PORT_F_PINS, 8'hEE);
    $display("test port f done");
    end_sim();
  end
endmodule
`default_nettype wire
